// ===== core/amdec_top.sv
// How it works
// - multiply A by X, high to X, low to A
// - inherent opcodes are one byte, no address
// - immediate byte is the operand, no address
// - direct: high byte zero, low from operand
// - extended: high byte then low byte
// - indexed no offset: address is X
// - indexed 8-bit: X plus offset, carry kept
// - indexed 16-bit: X plus high/low offset
// - branch adds signed offset to next address
// - register/memory takes register and memory operand
// - register/memory group includes listed operations
// - read-modify-write writes result back
// - read-modify-write group includes listed operations
// - bit set/clear decoded only as direct
// - test operation suppresses write-back
// - bit test branch copies bit into carry
//
// File holds the decoder top: opcode in, operand bytes in, address out.
// Assumes a fetch unit that presents opcode then operand bytes in order.
`timescale 1ns/1ns
`default_nettype none
`include "amdec_regs.svh"
module amdec_top (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RSTN,
    // Instruction byte stream
    input  wire logic                    OP_VALID,
    input  wire logic [7:0]              OP_BYTE,
    output logic                         OP_READY,
    // Register file view
    input  wire logic [7:0]              ACC_IN,
    input  wire logic [7:0]              IDX_IN,
    input  wire logic [15:0]             NEXT_PC,
    input  wire logic                    COND_TRUE,
    input  wire logic [7:0]              MEM_BYTE,
    // Decode results
    output logic                         DEC_DONE,
    output amdec_pkg::amdec_info_type    DEC_INFO,
    output amdec_pkg::amdec_opnd_type    DEC_OPND,
    output logic [15:0]                  BRANCH_PC,
    output logic                         PRODUCT_VALID,
    output logic [7:0]                   PRODUCT_ACC,
    output logic [7:0]                   PRODUCT_IDX,
    output logic                         BIT_CARRY
);
    amdec_pkg::amdec_state_type state_r;
    amdec_pkg::amdec_state_type state_nxt;
    amdec_pkg::amdec_info_type  info_now;
    amdec_pkg::amdec_info_type  info_r;
    logic [7:0]                 opcode_r;
    logic [7:0]                 b1_r;
    logic [7:0]                 b2_r;
    logic [15:0]                ea_nxt;
    logic [15:0]                prod;
    logic                       last_byte;
    logic [7:0]                 opnd_data_nxt;
    logic                       ea_valid_nxt;
    logic                       result_load;
    logic                       mul_load;
    logic                       tested_bit;
    logic [15:0]                rel_target;
    logic [15:0]                bit_target;

    // Classify the opcode as soon as it arrives
    amdec_table u_table (
        .opcode (OP_BYTE),
        .info   (info_now)
    );

    assign OP_READY = (state_r != amdec_pkg::ST_DONE);
    assign prod     = {8'h00, ACC_IN} * {8'h00, IDX_IN};

    // Last byte of the instruction this cycle
    always_comb begin
        last_byte = 1'b0;
        case (state_r)
            amdec_pkg::ST_IDLE:
                last_byte = (info_now.len == `AMDEC_LEN_ONE);
            amdec_pkg::ST_OPND1:
                last_byte = (info_r.len == `AMDEC_LEN_TWO);
            amdec_pkg::ST_OPND2:
                last_byte = 1'b1;
            default:
                last_byte = 1'b0;
        endcase
    end

    // Byte sequencing from the decoded length
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            amdec_pkg::ST_IDLE: begin
                if (OP_VALID) begin
                    state_nxt = last_byte ? amdec_pkg::ST_DONE
                                          : amdec_pkg::ST_OPND1;
                end
            end
            amdec_pkg::ST_OPND1: begin
                if (OP_VALID) begin
                    state_nxt = last_byte ? amdec_pkg::ST_DONE
                                          : amdec_pkg::ST_OPND2;
                end
            end
            amdec_pkg::ST_OPND2: begin
                if (OP_VALID) begin
                    state_nxt = amdec_pkg::ST_DONE;
                end
            end
            default:
                state_nxt = amdec_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= amdec_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Opcode and its class, taken with the first byte
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            opcode_r <= 8'h00;
            info_r   <= '0;
        end else if (OP_VALID && state_r == amdec_pkg::ST_IDLE) begin
            opcode_r <= OP_BYTE;
            info_r   <= info_now;
        end
    end

    // First operand byte
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            b1_r <= 8'h00;
        end else if (OP_VALID && state_r == amdec_pkg::ST_OPND1) begin
            b1_r <= OP_BYTE;
        end
    end

    // Second operand byte, low half of a long operand
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            b2_r <= 8'h00;
        end else if (OP_VALID && state_r == amdec_pkg::ST_OPND2) begin
            b2_r <= OP_BYTE;
        end
    end

    // Effective address per mode
    // Index is read in the done cycle, so it must stand there
    always_comb begin
        ea_nxt = 16'h0000;
        case (info_r.mode)
            amdec_pkg::AM_DIR: begin
                ea_nxt = {`AMDEC_HI_ZERO, b1_r};
            end
            amdec_pkg::AM_EXT: begin
                ea_nxt = {b1_r, b2_r};
            end
            amdec_pkg::AM_IX: begin
                ea_nxt = {`AMDEC_HI_ZERO, IDX_IN};
            end
            amdec_pkg::AM_IX1: begin
                ea_nxt = {`AMDEC_HI_ZERO, b1_r} +
                         {`AMDEC_HI_ZERO, IDX_IN};
            end
            amdec_pkg::AM_IX2: begin
                ea_nxt = {b1_r, b2_r} +
                         {`AMDEC_HI_ZERO, IDX_IN};
            end
            default: begin
                ea_nxt = 16'h0000;
            end
        endcase
    end

    // Operand data: immediate byte or the memory byte
    always_comb begin
        if (info_r.mode == amdec_pkg::AM_IMM) begin
            opnd_data_nxt = b1_r;
        end else begin
            opnd_data_nxt = MEM_BYTE;
        end
    end

    // An address exists for every mode but these three
    // Branch offsets are not addresses of an operand
    always_comb begin
        ea_valid_nxt = 1'b1;
        if (info_r.mode == amdec_pkg::AM_INH ||
            info_r.mode == amdec_pkg::AM_IMM ||
            info_r.mode == amdec_pkg::AM_REL) begin
            ea_valid_nxt = 1'b0;
        end
    end

    // Results load at the end of the done cycle
    assign result_load = (state_r == amdec_pkg::ST_DONE);

    // Multiply results load with the others
    assign mul_load = result_load && (opcode_r == `AMDEC_OP_MUL);

    // Tested bit of the memory byte for bit-test branches
    assign tested_bit = MEM_BYTE[opcode_r[3:1]];

    // Targets: signed offset added to the next address
    assign rel_target = NEXT_PC + {{8{b1_r[7]}}, b1_r};
    assign bit_target = NEXT_PC + {{8{b2_r[7]}}, b2_r};

    // Done pulse, high through the done cycle
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DEC_DONE <= 1'b0;
        end else begin
            DEC_DONE <= (state_nxt == amdec_pkg::ST_DONE);
        end
    end

    // Class of the instruction
    // Shows one cycle after the done pulse, held until the next
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DEC_INFO <= '0;
        end else if (result_load) begin
            DEC_INFO <= info_r;
        end
    end

    // Operand address, data and address flag
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DEC_OPND <= '0;
        end else if (result_load) begin
            DEC_OPND.ea       <= ea_nxt;
            DEC_OPND.data     <= opnd_data_nxt;
            DEC_OPND.ea_valid <= ea_valid_nxt;
        end
    end

    // Branch target for relative and bit-test branches
    // Other instructions leave the last target standing
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            BRANCH_PC <= 16'h0000;
        end else if (result_load &&
                     info_r.cat == amdec_pkg::CAT_BRANCH) begin
            if (info_r.mode == amdec_pkg::AM_REL) begin
                if (COND_TRUE) begin
                    BRANCH_PC <= rel_target;
                end else begin
                    BRANCH_PC <= NEXT_PC;
                end
            end else if (tested_bit != opcode_r[0]) begin
                BRANCH_PC <= bit_target;
            end else begin
                BRANCH_PC <= NEXT_PC;
            end
        end
    end

    // Carry copy of the tested bit
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            BIT_CARRY <= 1'b0;
        end else if (result_load &&
                     info_r.cat == amdec_pkg::CAT_BRANCH &&
                     info_r.mode != amdec_pkg::AM_REL) begin
            BIT_CARRY <= tested_bit;
        end
    end

    // Multiply pulse, with the product halves
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRODUCT_VALID <= 1'b0;
        end else begin
            PRODUCT_VALID <= mul_load;
        end
    end

    // Product halves: high to index, low to accumulator
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRODUCT_ACC <= 8'h00;
            PRODUCT_IDX <= 8'h00;
        end else if (mul_load) begin
            PRODUCT_IDX <= prod[15:8];
            PRODUCT_ACC <= prod[7:0];
        end
    end
endmodule
`default_nettype wire

// ===== core/amdec_regs.svh
// Constants of the address-mode decoder: opcode fields, byte counts.
// Assumes inclusion by bare name from core files.
`ifndef AMDEC_REGS_SVH
`define AMDEC_REGS_SVH
`define AMDEC_HI_ZERO       8'h00
`define AMDEC_LEN_ONE       2'h1
`define AMDEC_LEN_TWO       2'h2
`define AMDEC_LEN_THREE     2'h3
`define AMDEC_ROW_BITTST    4'h0
`define AMDEC_ROW_BITMAN    4'h1
`define AMDEC_ROW_REL       4'h2
`define AMDEC_ROW_RMW_DIR   4'h3
`define AMDEC_ROW_RMW_A     4'h4
`define AMDEC_ROW_RMW_X     4'h5
`define AMDEC_ROW_RMW_IX1   4'h6
`define AMDEC_ROW_RMW_IX    4'h7
`define AMDEC_ROW_CTL0      4'h8
`define AMDEC_ROW_CTL1      4'h9
`define AMDEC_ROW_IMM       4'hA
`define AMDEC_ROW_DIR       4'hB
`define AMDEC_ROW_EXT       4'hC
`define AMDEC_ROW_IX2       4'hD
`define AMDEC_ROW_IX1       4'hE
`define AMDEC_ROW_IX        4'hF
`define AMDEC_OP_MUL        8'h42
`define AMDEC_COL_STA       4'h7
`define AMDEC_COL_STX       4'hF
`define AMDEC_COL_TST       4'hD
`define AMDEC_COL_CLR       4'hF
`endif

// ===== core/amdec_pkg.sv
// Types of the address-mode decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package amdec_pkg;
    typedef enum logic [3:0] {
        AM_INH = 4'h0, AM_IMM = 4'h1, AM_DIR = 4'h3, AM_EXT = 4'h2,
        AM_IX  = 4'h6, AM_IX1 = 4'h7, AM_IX2 = 4'h5, AM_REL = 4'h4
    } amdec_mode_type;
    typedef enum logic [2:0] {
        CAT_REGMEM = 3'h0, CAT_RMW = 3'h1, CAT_BRANCH = 3'h2,
        CAT_BITMAN = 3'h3, CAT_CONTROL = 3'h4
    } amdec_cat_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0, ST_OPND1 = 2'h1, ST_OPND2 = 2'h3, ST_DONE = 2'h2
    } amdec_state_type;
    typedef struct packed {
        amdec_mode_type mode;
        amdec_cat_type  cat;
        logic [1:0]     len;
        logic           writes_back;
        logic           uses_index;
    } amdec_info_type;
    typedef struct packed {
        logic [15:0] ea;
        logic [7:0]  data;
        logic        ea_valid;
    } amdec_opnd_type;
endpackage

// ===== core/amdec_table.sv
// Opcode classifier: mode, category, length and write-back from opcode.
// Assumes an 8-bit opcode; purely combinational.
`timescale 1ns/1ns
`default_nettype none
`include "amdec_regs.svh"
module amdec_table (
    // Opcode in
    input  wire logic [7:0]              opcode,
    // Classification out
    output amdec_pkg::amdec_info_type    info
);
    logic [3:0] row;
    logic [3:0] col;
    assign row = opcode[7:4];
    assign col = opcode[3:0];

    // Row gives mode and category (MUL by its whole opcode), column sets write-back in read-modify-write and register/memory rows
    always_comb begin
        info.mode        = amdec_pkg::AM_INH;
        info.cat         = amdec_pkg::CAT_CONTROL;
        info.len         = `AMDEC_LEN_ONE;
        info.writes_back = 1'b0;
        info.uses_index  = 1'b0;
        if (opcode == `AMDEC_OP_MUL) begin
            info.cat = amdec_pkg::CAT_REGMEM;
        end else if (row == `AMDEC_ROW_BITTST) begin
            info.mode = amdec_pkg::AM_DIR;
            info.cat  = amdec_pkg::CAT_BRANCH;
            info.len  = `AMDEC_LEN_THREE;
        end else if (row == `AMDEC_ROW_BITMAN) begin
            info.mode        = amdec_pkg::AM_DIR;
            info.cat         = amdec_pkg::CAT_BITMAN;
            info.len         = `AMDEC_LEN_TWO;
            info.writes_back = 1'b1;
        end else if (row == `AMDEC_ROW_REL) begin
            info.mode = amdec_pkg::AM_REL;
            info.cat  = amdec_pkg::CAT_BRANCH;
            info.len  = `AMDEC_LEN_TWO;
        end else if (row >= `AMDEC_ROW_RMW_DIR &&
                     row <= `AMDEC_ROW_RMW_IX) begin
            info.cat         = amdec_pkg::CAT_RMW;
            info.writes_back = (col != `AMDEC_COL_TST);
            if (row == `AMDEC_ROW_RMW_DIR) begin
                info.mode = amdec_pkg::AM_DIR;
                info.len  = `AMDEC_LEN_TWO;
            end else if (row == `AMDEC_ROW_RMW_IX1) begin
                info.mode       = amdec_pkg::AM_IX1;
                info.len        = `AMDEC_LEN_TWO;
                info.uses_index = 1'b1;
            end else if (row == `AMDEC_ROW_RMW_IX) begin
                info.mode       = amdec_pkg::AM_IX;
                info.uses_index = 1'b1;
            end
        end else if (row == `AMDEC_ROW_CTL0 || row == `AMDEC_ROW_CTL1) begin
            info.cat = amdec_pkg::CAT_CONTROL;
        end else begin
            info.cat = amdec_pkg::CAT_REGMEM;
            info.writes_back = (col == `AMDEC_COL_STA) ||
                               (col == `AMDEC_COL_STX);
            if (row == `AMDEC_ROW_IMM) begin
                info.mode = amdec_pkg::AM_IMM;
                info.len  = `AMDEC_LEN_TWO;
            end else if (row == `AMDEC_ROW_DIR) begin
                info.mode = amdec_pkg::AM_DIR;
                info.len  = `AMDEC_LEN_TWO;
            end else if (row == `AMDEC_ROW_EXT) begin
                info.mode = amdec_pkg::AM_EXT;
                info.len  = `AMDEC_LEN_THREE;
            end else if (row == `AMDEC_ROW_IX2) begin
                info.mode       = amdec_pkg::AM_IX2;
                info.len        = `AMDEC_LEN_THREE;
                info.uses_index = 1'b1;
            end else if (row == `AMDEC_ROW_IX1) begin
                info.mode       = amdec_pkg::AM_IX1;
                info.len        = `AMDEC_LEN_TWO;
                info.uses_index = 1'b1;
            end else begin
                info.mode       = amdec_pkg::AM_IX;
                info.uses_index = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/amdec_top_properties.sv
// Checker of the address-mode decoder's output relations.
// Assumes it is bound onto amdec_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module amdec_checker (
    // Clock and reset
    input wire logic                      CLK,
    input wire logic                      RSTN,
    // Handshake and sampled inputs
    input wire logic                      OP_READY,
    input wire logic [7:0]                IDX_IN,
    input wire logic [15:0]               NEXT_PC,
    input wire logic                      COND_TRUE,
    // Decode results
    input wire logic                      DEC_DONE,
    input wire amdec_pkg::amdec_info_type DEC_INFO,
    input wire amdec_pkg::amdec_opnd_type DEC_OPND,
    input wire logic [15:0]               BRANCH_PC
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Handshake and result timing
    property p_rdy; OP_READY == !DEC_DONE; endproperty
    a_rdy: assert property (p_rdy) else $error("ready not inverse of done");
    property p_done; $rose(DEC_DONE) |-> !OP_READY ##1 OP_READY && !DEC_DONE; endproperty
    a_done: assert property (p_done) else $error("done not one cycle");
    property p_hold; !$past(DEC_DONE) |-> $stable(DEC_OPND) && $stable(BRANCH_PC); endproperty
    a_hold: assert property (p_hold) else $error("result moved between decodes");
    // Address forming per mode
    property p_dir; DEC_INFO.mode == amdec_pkg::AM_DIR |-> DEC_OPND.ea[15:8] == 8'h00; endproperty
    a_dir: assert property (p_dir) else $error("direct high byte not zero");
    property p_ix; $past(DEC_DONE) && DEC_INFO.mode == amdec_pkg::AM_IX
        |-> DEC_OPND.ea == {8'h00, $past(IDX_IN)}; endproperty
    a_ix: assert property (p_ix) else $error("indexed address not index");
    property p_ix1; $past(DEC_DONE) && DEC_INFO.mode == amdec_pkg::AM_IX1
        |-> DEC_OPND.ea <= 16'h01FE && DEC_OPND.ea >= {8'h00, $past(IDX_IN)}; endproperty
    a_ix1: assert property (p_ix1) else $error("short offset address out of span");
    property p_imm; DEC_INFO.mode == amdec_pkg::AM_IMM |-> !DEC_OPND.ea_valid && DEC_INFO.len == 2'h2; endproperty
    a_imm: assert property (p_imm) else $error("immediate formed an address");
    property p_inh; $past(DEC_DONE) && DEC_INFO.mode == amdec_pkg::AM_INH
        |-> DEC_INFO.len == 2'h1 && !DEC_OPND.ea_valid; endproperty
    a_inh: assert property (p_inh) else $error("inherent length or address wrong");
    property p_long; DEC_INFO.mode inside {amdec_pkg::AM_EXT, amdec_pkg::AM_IX2} |-> DEC_INFO.len == 2'h3; endproperty
    a_long: assert property (p_long) else $error("long mode not three bytes");
    property p_rel; $past(DEC_DONE) && DEC_INFO.mode == amdec_pkg::AM_REL && DEC_INFO.len == 2'h2
        && !$past(COND_TRUE) |-> BRANCH_PC == $past(NEXT_PC); endproperty
    a_rel: assert property (p_rel) else $error("untaken branch moved");
    property p_bitman; DEC_INFO.cat == amdec_pkg::CAT_BITMAN |-> DEC_INFO.mode == amdec_pkg::AM_DIR; endproperty
    a_bitman: assert property (p_bitman) else $error("bit set or clear not direct");
endmodule

bind amdec_top amdec_checker u_checker (
    .CLK(CLK), .RSTN(RSTN), .OP_READY(OP_READY), .IDX_IN(IDX_IN),
    .NEXT_PC(NEXT_PC), .COND_TRUE(COND_TRUE), .DEC_DONE(DEC_DONE),
    .DEC_INFO(DEC_INFO), .DEC_OPND(DEC_OPND), .BRANCH_PC(BRANCH_PC)
);
`default_nettype wire

// ===== bench/amdec_top_bench.sv
// Self-checking bench of the address-mode decoder.
// Assumes the package and amdec_top are compiled first.
`timescale 1ns/1ns
`default_nettype none
module amdec_top_bench;
    logic                      CLK, RSTN, OP_VALID, COND_TRUE;
    logic [7:0]                OP_BYTE, ACC_IN, IDX_IN, MEM_BYTE;
    logic [15:0]               NEXT_PC;
    wire logic                 OP_READY, DEC_DONE, PRODUCT_VALID, BIT_CARRY;
    wire amdec_pkg::amdec_info_type DEC_INFO;
    wire amdec_pkg::amdec_opnd_type DEC_OPND;
    wire logic [15:0]          BRANCH_PC;
    wire logic [7:0]           PRODUCT_ACC, PRODUCT_IDX;
    int                        bad_count = 0;
    int                        checked = 0;

    amdec_top DUT (.CLK(CLK), .RSTN(RSTN), .OP_VALID(OP_VALID),
        .OP_BYTE(OP_BYTE), .OP_READY(OP_READY), .ACC_IN(ACC_IN),
        .IDX_IN(IDX_IN), .NEXT_PC(NEXT_PC), .COND_TRUE(COND_TRUE),
        .MEM_BYTE(MEM_BYTE), .DEC_DONE(DEC_DONE), .DEC_INFO(DEC_INFO),
        .DEC_OPND(DEC_OPND), .BRANCH_PC(BRANCH_PC),
        .PRODUCT_VALID(PRODUCT_VALID), .PRODUCT_ACC(PRODUCT_ACC),
        .PRODUCT_IDX(PRODUCT_IDX), .BIT_CARRY(BIT_CARRY));

    // 25 MHz clock
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    // Compare, count, report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_mc(input amdec_pkg::amdec_mode_type md, input amdec_pkg::amdec_cat_type ct, input logic [1:0] ln);
        chk({12'h000, DEC_INFO.mode}, {12'h000, md}, "mode");
        chk({13'h0000, DEC_INFO.cat}, {13'h0000, ct}, "category");
        chk({14'h0000, DEC_INFO.len}, {14'h0000, ln}, "length");
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Register view seen during the decode
    task automatic setregs(input logic [7:0] a, x, m, input logic [15:0] pc, input logic c);
        @(posedge CLK);
        ACC_IN    <= a;
        IDX_IN    <= x;
        MEM_BYTE  <= m;
        NEXT_PC   <= pc;
        COND_TRUE <= c;
    endtask
    // Feed one instruction, wait for done, settle on updated results
    task automatic run(input logic [7:0] op, b1, b2, input int n);
        logic [7:0] bs [3];
        int         i;
        bs = '{op, b1, b2};
        @(posedge CLK);
        for (i = 0; i < n; i++) begin
            OP_VALID <= 1'b1;
            OP_BYTE  <= bs[i];
            @(posedge CLK);
        end
        OP_VALID <= 1'b0;
        OP_BYTE  <= ~bs[n-1];
        #1;
        for (i = 0; i < 8 && DEC_DONE !== 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        chk(16'(i), 16'h0000, "done latency");
        if (i == 8) begin
            conclude();
        end
        @(posedge CLK);
        #1;
    endtask

    task automatic t_mul_imm;
        setregs(8'hFF, 8'hFE, 8'h00, 16'h0000, 1'b0);
        run(8'h42, 8'h00, 8'h00, 1);
        chk({PRODUCT_IDX, PRODUCT_ACC}, 16'hFD02, "product");
        chk({15'h0000, PRODUCT_VALID}, 16'h0001, "product valid");
        chk({12'h000, DEC_INFO.mode}, 16'h0000, "inherent mode");
        chk_mc(amdec_pkg::AM_INH, amdec_pkg::CAT_REGMEM, 2'h1);
        run(8'h9D, 8'h00, 8'h00, 1);
        chk_mc(amdec_pkg::AM_INH, amdec_pkg::CAT_CONTROL, 2'h1);
        chk({15'h0000, PRODUCT_VALID}, 16'h0000, "no product");
        run(8'hA6, 8'h5A, 8'h00, 2);
        chk_mc(amdec_pkg::AM_IMM, amdec_pkg::CAT_REGMEM, 2'h2);
        chk({8'h00, DEC_OPND.data}, 16'h005A, "immediate data");
    endtask
    task automatic t_modes;
        logic [7:0]  op [5] = '{8'hB6, 8'hC6, 8'hF6, 8'hE6, 8'hD6};
        logic [7:0]  b1 [5] = '{8'h80, 8'h12, 8'h00, 8'hFF, 8'hFF};
        logic [7:0]  b2 [5] = '{8'h00, 8'h34, 8'h00, 8'h00, 8'hFF};
        logic [7:0]  ix [5] = '{8'h11, 8'h11, 8'hFF, 8'hFF, 8'h02};
        logic [15:0] ea [5] = '{16'h0080, 16'h1234, 16'h00FF, 16'h01FE, 16'h0001};
        int          ln [5] = '{2, 3, 1, 2, 3};
        amdec_pkg::amdec_mode_type md [5] = '{amdec_pkg::AM_DIR,
            amdec_pkg::AM_EXT, amdec_pkg::AM_IX, amdec_pkg::AM_IX1, amdec_pkg::AM_IX2};
        for (int i = 0; i < 5; i++) begin
            setregs(8'h00, ix[i], 8'h00, 16'h0000, 1'b0);
            run(op[i], b1[i], b2[i], ln[i]);
            chk(DEC_OPND.ea, ea[i], "address");
            chk_mc(md[i], amdec_pkg::CAT_REGMEM, 2'(ln[i]));
            chk({15'h0000, DEC_INFO.uses_index}, {15'h0000, i > 1}, "index use");
        end
    endtask
    task automatic t_regmem_bits;
        for (int c = 0; c < 16; c++) begin
            if (c == 12 || c == 13) continue;
            run({4'hB, 4'(c)}, 8'h21, 8'h00, 2);
            chk_mc(amdec_pkg::AM_DIR, amdec_pkg::CAT_REGMEM, 2'h2);
            chk(DEC_OPND.ea, 16'h0021, "address");
        end
        run(8'h10, 8'h33, 8'h00, 2);
        chk_mc(amdec_pkg::AM_DIR, amdec_pkg::CAT_BITMAN, 2'h2);
        run(8'h1F, 8'h33, 8'h00, 2);
        chk(DEC_OPND.ea, 16'h0033, "bit address");
    endtask
    task automatic t_rmw;
        logic [3:0] col [11] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hF};
        for (int i = 0; i < 11; i++) begin
            run({4'h3, col[i]}, 8'h40, 8'h00, 2);
            chk_mc(amdec_pkg::AM_DIR, amdec_pkg::CAT_RMW, 2'h2);
            chk({15'h0000, DEC_INFO.writes_back}, {15'h0000, col[i] != 4'hD}, "write back");
        end
        run(8'h7D, 8'h00, 8'h00, 1);
        chk_mc(amdec_pkg::AM_IX, amdec_pkg::CAT_RMW, 2'h1);
        chk({15'h0000, DEC_INFO.writes_back}, 16'h0000, "test write back");
    endtask
    task automatic t_branch;
        logic [7:0]  op [3] = '{8'h0E, 8'h0F, 8'h01};
        logic [7:0]  m [3]  = '{8'h80, 8'h80, 8'hFE};
        logic [15:0] pc [3] = '{16'h2010, 16'h2000, 16'h2010};
        setregs(8'h00, 8'h00, 8'h00, 16'h1000, 1'b1);
        run(8'h20, 8'h80, 8'h00, 2);
        chk(BRANCH_PC, 16'h0F80, "branch back");
        chk_mc(amdec_pkg::AM_REL, amdec_pkg::CAT_BRANCH, 2'h2);
        run(8'h20, 8'h7F, 8'h00, 2);
        chk(BRANCH_PC, 16'h107F, "branch forward");
        setregs(8'h00, 8'h00, 8'h00, 16'h1000, 1'b0);
        run(8'h26, 8'h7F, 8'h00, 2);
        chk(BRANCH_PC, 16'h1000, "branch untaken");
        for (int i = 0; i < 3; i++) begin
            setregs(8'h00, 8'h00, m[i], 16'h2000, 1'b0);
            run(op[i], 8'h44, 8'h10, 3);
            chk({15'h0000, BIT_CARRY}, {15'h0000, i < 2}, "bit carry");
            chk(BRANCH_PC, pc[i], "bit branch");
            chk({8'h00, DEC_OPND.data}, {8'h00, m[i]}, "memory operand");
        end
    endtask

    // Reset, scenarios, mid-run reset, verdict
    initial begin
        RSTN = 1'b0;
        OP_VALID = 1'b0;
        OP_BYTE = 8'h00;
        ACC_IN = 8'h00;
        IDX_IN = 8'h00;
        MEM_BYTE = 8'h00;
        NEXT_PC = 16'h0000;
        COND_TRUE = 1'b0;
        repeat (16) @(posedge CLK);
        chk({14'h0000, OP_READY, DEC_DONE}, 16'h0002, "reset outputs");
        RSTN <= 1'b1;
        t_mul_imm();
        t_modes();
        t_regmem_bits();
        t_rmw();
        t_branch();
        @(posedge CLK);
        RSTN <= 1'b0;
        @(posedge CLK);
        chk(DEC_OPND.ea, 16'h0000, "address cleared");
        RSTN <= 1'b1;
        run(8'hC6, 8'hAB, 8'hCD, 3);
        chk(DEC_OPND.ea, 16'hABCD, "address after reset");
        conclude();
    end
endmodule
`default_nettype wire
